// ===== dv/rldf_core_assertions.sv
/* Port checker for rldf_core.
   Assumes one clock domain; bound to every rldf_core instance. */
`timescale 1ns/10ps
module rldf_core_chk import rldf_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched ports
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire rldf_byte_t serOut,
  input wire logic serOutValid,
  input wire logic serOutReady,
  input wire rldf_byte_t radioTx,
  input wire logic radioTxValid,
  input wire logic radioTxReady,
  input wire logic radioTxOn,
  input wire logic radioRxEnable,
  input wire rldf_chan_t activeChan,
  input wire logic rxOnly,
  input wire logic crcFail
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_txStall; radioTxValid && !radioTxReady; endsequence
  sequence s_serStall; serOutValid && !serOutReady; endsequence
  a_read_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_tx_hold: assert property (s_txStall |=> radioTxValid && $stable(radioTx))
    else $error("radio byte dropped while stalled");
  a_ser_hold: assert property (s_serStall |=> serOutValid && $stable(serOut))
    else $error("serial byte dropped while stalled");
  a_rx_blocked: assert property (radioTxValid |-> !radioRxEnable)
    else $error("receiver enabled while sending");
  a_tx_keyed: assert property ($rose(radioTxValid) |-> $past(radioTxOn))
    else $error("byte offered with transmitter off");
  a_rx_only: assert property ($stable(activeChan) |->
    rxOnly == (activeChan.txFreq == 32'h0 && activeChan.rxFreq != 32'h0))
    else $error("receive-only flag wrong");
  a_fail_pulse: assert property (crcFail |=> !crcFail)
    else $error("check failure not a single pulse");
  a_trailer_end: assert property (serOutValid && serOut.last |-> serOut.data == 8'h0A)
    else $error("message end not line feed");
endmodule
bind rldf_core rldf_core_chk u_chk (.clk_sys, .reset_n, .regRd, .regRdData, .serOut, .serOutValid,
  .serOutReady, .radioTx, .radioTxValid, .radioTxReady, .radioTxOn, .radioRxEnable, .activeChan, .rxOnly,
  .crcFail);

// ===== dv/rldf_core_tb.sv
/* Bench for rldf_core: registers, receive check modes, level trailer, transmit delay.
   Assumes MS_CYCLES of 10 and a 100 MHz clock. */
`timescale 1ns/10ps
module rldf_core_tb import rldf_pkg::*; ();
  logic clk_sys = 1'h0, reset_n = 1'h0, regWr = 1'h0, regRd = 1'h0, hostInValid = 1'h0, radioRxValid = 1'h0;
  logic radioTxReady = 1'h0, hostInReady, serOutValid, serOutReady, radioTxValid, radioTxMorse, radioTxOn;
  logic radioRxEnable, rxOnly, crcFail;
  logic [7:0] regAddr = 8'h00, rxLevelDbm = 8'h5F, c;
  logic [31:0] regWrData = 32'h0, regRdData;
  rldf_byte_t hostIn = 9'h000, radioRx = 9'h000, serOut, radioTx;
  rldf_chan_t activeChan;
  int badCount = 0, samplesChecked = 0, cnt;
  always #5 clk_sys = !clk_sys;
  always @(posedge clk_sys) radioTxReady <= !radioTxReady;
  rldf_core #(.MS_CYCLES(10)) dut (.clk_sys, .reset_n, .clkEn(1'h1), .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .hostIn, .hostInValid, .hostInReady, .serOut, .serOutValid, .serOutReady, .radioTx,
    .radioTxValid, .radioTxReady, .radioTxMorse, .radioTxOn, .radioRx, .radioRxValid, .radioRxBusy(1'h0),
    .rxLevelDbm, .radioRxEnable, .band900(1'h0), .activeChan, .rxOnly, .crcFail);
  rldf_term_model term (.clk_sys, .serOut, .serOutValid, .serOutReady);
  task automatic chk(input string n, input logic [31:0] s, e);
    samplesChecked++;
    if (s !== e) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic printVerdict;
    $display("Checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 chk("register", regRdData, e);
  endtask
  task automatic rx(input logic [7:0] d, input logic l);
    @(posedge clk_sys);
    radioRx <= '{data: d, last: l};
    radioRxValid <= 1'h1;
    @(posedge clk_sys);
    radioRxValid <= 1'h0;
  endtask
  task automatic drain(input string s);
    repeat (80) @(posedge clk_sys);
    chk("count", term.got.size(), s.len());
    foreach (s[i]) chk("byte", term.got[i], s[i]);
    term.got.delete();
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] p, d);
    crc8 = p ^ d;
    repeat (8) crc8 = crc8[7] ? {crc8[6:0], 1'h0} ^ CRC8_POLY : {crc8[6:0], 1'h0};
  endfunction
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'h1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_TXDELAY, 32'h0);
    rd(ADDR_CALLCFG, 32'h0000000A);
    rd(8'hFC, 32'h0);
    wr(ADDR_CHRXF, 32'h1);
    wr(ADDR_CHCFG, 32'h0);
    rd(ADDR_CHRXF, 32'h1);
    chk("rxonly", rxOnly, 1);
    $display("Registers done");
    wr(ADDR_CTRL, 32'h8);
    rx(8'h41, 1'h0);
    rx(8'h42, 1'h1);
    drain("AB\002RSSI:-095 dBm\003\015\012");
    $display("Level trailer done");
    wr(ADDR_CTRL, {30'h0, ERR_CRC8F});
    rx(8'h47, 1'h0);
    rx(crc8(8'h00, 8'h47), 1'h1);
    rx(8'h48, 1'h0);
    rx(~crc8(8'h00, 8'h48), 1'h1);
    drain("G");
    wr(ADDR_CTRL, {30'h0, ERR_CRC8P});
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rx(8'h30 + i[7:0], 1'h0);
      c = crc8(c, 8'h30 + i[7:0]);
    end
    rx(c, 1'h0);
    rx(8'h39, 1'h0);
    rx(8'h00, 1'h1);
    drain("01234567");
    rd(ADDR_FAILCNT, 32'h2);
    $display("Check modes done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_TXDELAY, 32'h2);
    @(posedge clk_sys);
    hostIn <= '{data: 8'h54, last: 1'h1};
    hostInValid <= 1'h1;
    @(posedge clk_sys);
    hostInValid <= 1'h0;
    cnt = 0;
    while (radioTxValid !== 1'h1 && cnt < 200) begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    chk("delay", cnt >= 20 && cnt <= 30, 1);
    chk("txbyte", radioTx, {8'h54, 1'h1});
    $display("Transmit delay done");
    repeat (20) @(posedge clk_sys);
    printVerdict();
  end
  initial begin
    #100000;
    badCount++;
    printVerdict();
  end
endmodule

// ===== dv/rldf_term_model.sv
/* Terminal on the serial output: takes bytes and keeps them.
   Assumes the block clock; the bench reads and clears got. */
`timescale 1ns/10ps
module rldf_term_model import rldf_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Serial stream
  input wire rldf_byte_t serOut,
  input wire logic serOutValid,
  output logic serOutReady
);
  logic [7:0] got[$];
  initial serOutReady = 1'h0;
  // A slow terminal accepts on alternate edges, so held bytes get exercised.
  always @(posedge clk_sys) begin
    if (serOutValid && serOutReady) got.push_back(serOut.data);
    serOutReady <= !serOutReady;
  end
endmodule

// ===== rtl/rldf_core.sv
/*
  Data-path features of a radio modem between the terminal serial stream and the radio byte stream:
  error-check modes, transmit delay with buffering, level trailer, split-frequency switching,
  periodic call-sign sending and a stored channel list.
  Assumes byte streams with valid/ready, a radio front end that reports reception in progress,
  and one synchronous clock domain.
*/
// Summary of operation
// (R1) Checksum appended on send, verified on receive
// (R2) Check off forwards received bytes at once
// (R3) Partial mode releases each validated small block
// (R4) Failed block drops rest of message
// (R5) Full modes release packet only when check matches
// (R6) CRC-8 and CRC-16 both stripped from received data
// (R7) Check off passes CRC-16 characters through
// (R8) Full checking waits for whole packet
// (R9) High band disables all link features; the stored channel list is not masked and stays active
// (R10) Transmission start postponed by configured milliseconds
// (R11) Terminal data buffered during delay
// (R12) No receive while delay runs
// (R13) Delay of zero means no delay
// (R14) Level trailer appended to serial messages
// (R15) Each frequency switch adds 40 ms
// (R16) Call sign sent periodically, off by default
// (R17) Identifier up to sixteen upper-case characters
// (R18) Call interval one to thirty minutes
// (R19) Channel entry holds number, frequencies, width, power
// (R20) Default channel becomes active after reset
// (R21) Zero transmit frequency means receive-only
// (R22) Host builds channel list in fixed order
// (R23) Receive priority waits for reception end
// (R24) Conventional CRC-8 and CRC-16 polynomials used
// (R25) Checksum failure gives distinct status
`timescale 1ns/10ps
module rldf_core import rldf_pkg::*; #(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Terminal stream into the modem
  input wire rldf_byte_t hostIn,
  input wire logic hostInValid,
  output logic hostInReady,
  // Serial stream out to the terminal
  output rldf_byte_t serOut,
  output logic serOutValid,
  input wire logic serOutReady,
  // Radio transmit side
  output rldf_byte_t radioTx,
  output logic radioTxValid,
  input wire logic radioTxReady,
  output logic radioTxMorse,
  output logic radioTxOn,
  // Radio receive side
  input wire rldf_byte_t radioRx,
  input wire logic radioRxValid,
  input wire logic radioRxBusy,
  input wire logic [7:0] rxLevelDbm,
  output logic radioRxEnable,
  // Band, channel and check failure
  input wire logic band900,
  output rldf_chan_t activeChan,
  output logic rxOnly,
  output logic crcFail
);

  // (R24) conventional CRC polynomials
  function automatic logic [7:0] crc8_next(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC8_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16_next(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ CRC16_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [7:0] trailer_byte(input logic [4:0] idx, input logic [7:0] lvl);
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      5'd0: r = 8'h02;
      5'd1: r = 8'h52;
      5'd2: r = 8'h53;
      5'd3: r = 8'h53;
      5'd4: r = 8'h49;
      5'd5: r = 8'h3A;
      5'd6: r = 8'h2D;
      5'd7: r = 8'h30 + 8'(lvl / 8'd100);
      5'd8: r = 8'h30 + 8'((lvl / 8'd10) % 8'd10);
      5'd9: r = 8'h30 + 8'(lvl % 8'd10);
      5'd10: r = 8'h20;
      5'd11: r = 8'h64;
      5'd12: r = 8'h42;
      5'd13: r = 8'h6D;
      5'd14: r = 8'h03;
      5'd15: r = 8'h0D;
      default: r = 8'h0A;
    endcase
    return r;
  endfunction

  logic [CTRL_W-1:0] ctrl;
  logic [15:0] txDelayMs;
  logic [4:0] callMin;
  logic [4:0] callLen;
  logic [7:0] callId [ID_LEN];
  logic [CH_AW-1:0] chIdx, chCount, chDefault, activeIdx;
  rldf_chan_t chStage;
  rldf_chan_t chMem [2**CH_AW];
  logic bootLoad;
  logic [15:0] failCnt;
  logic rxOverflow;

  // (R9) high band masks
  wire logic featOn = !band900;
  wire rldf_err_t effErr = featOn ? rldf_err_t'(ctrl[CTRL_ERR_LSB +: 2]) : ERR_OFF;
  // (R13) zero delay
  wire logic [15:0] effDelay = featOn ? txDelayMs : 16'h0000;
  wire logic rxPrio = featOn && ctrl[CTRL_RXPRIO];
  wire logic rssiOn = featOn && ctrl[CTRL_RECEIVED_SIGNAL_LEVEL];
  wire logic splitOn = featOn && ctrl[CTRL_SPLIT];
  wire logic callOn = featOn && ctrl[CTRL_CALL];

  wire logic wrSel = regWr && clkEn;
  wire logic wrCtrl = wrSel && regAddr == ADDR_CTRL;
  wire logic wrCallChar = wrSel && regAddr == ADDR_CALLCHAR;
  wire logic wrChCfg = wrSel && regAddr == ADDR_CHCFG;
  wire logic wrFail = wrSel && regAddr == ADDR_FAILCNT;
  // (R17) lower case folded to upper case
  wire logic [7:0] callChar = (regWrData[7:0] >= 8'h61 && regWrData[7:0] <= 8'h7A) ?
    regWrData[7:0] - 8'h20 : regWrData[7:0];

  // (R16) call sign off by default
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
      txDelayMs <= TXDELAY_RESET;
      callMin <= CALLMIN_RESET;
      callLen <= 5'h00;
      chIdx <= '0;
      chCount <= '0;
      chDefault <= '0;
      chStage <= '0;
    end else if (wrSel) begin
      unique case (regAddr)
        ADDR_CTRL: ctrl <= regWrData[CTRL_W-1:0];
        ADDR_TXDELAY: txDelayMs <= regWrData[15:0];
        // (R18) interval clamped to range
        ADDR_CALLCFG: begin
          callMin <= (regWrData[4:0] == 5'h00) ? 5'h01 : (regWrData[4:0] > 5'd30) ? 5'd30 : regWrData[4:0];
          callLen <= (regWrData[CALLCFG_LEN_LSB +: 5] > 5'd16) ? 5'd16 : regWrData[CALLCFG_LEN_LSB +: 5];
        end
        ADDR_CHIDX: chIdx <= regWrData[CH_AW-1:0];
        ADDR_CHNUM: chStage.num <= regWrData[15:0];
        ADDR_CHTXF: chStage.txFreq <= regWrData;
        ADDR_CHRXF: chStage.rxFreq <= regWrData;
        ADDR_CHCOUNT: chCount <= regWrData[CH_AW-1:0];
        ADDR_CHDEFAULT: chDefault <= regWrData[CH_AW-1:0];
        default: ;
      endcase
    end
  end

  // (R19) channel entry stored on config write
  always_ff @(posedge clk_sys) begin
    if (wrCallChar) begin
      callId[regWrData[11:8]] <= callChar;
    end
    if (wrChCfg) begin
      chMem[chIdx] <= '{num: chStage.num, txFreq: chStage.txFreq, rxFreq: chStage.rxFreq,
        width: rldf_width_t'(regWrData[1:0]), power: regWrData[CHCFG_POWER_LSB +: 4]};
    end
  end

  // (R20) default channel taken once after reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bootLoad <= 1'b1;
      activeIdx <= '0;
      activeChan <= '0;
      rxOnly <= 1'b0;
    end else if (clkEn) begin
      if (bootLoad) begin
        activeIdx <= chDefault;
        bootLoad <= 1'b0;
      end else if (wrSel && regAddr == ADDR_CHSELECT) begin
        activeIdx <= regWrData[CH_AW-1:0];
      end
      activeChan <= chMem[activeIdx];
      // (R21) receive-only channel
      rxOnly <= chMem[activeIdx].txFreq == 32'h0 && chMem[activeIdx].rxFreq != 32'h0;
    end
  end

  // Free-running millisecond tick for the call-sign interval.
  logic [16:0] tickCnt;
  logic [20:0] callMs;
  logic callPend;
  wire logic msTick = tickCnt == 17'(MS_CYCLES - 1);
  wire logic [20:0] callLimit = 21'(21'(callMin) * MS_PER_MIN);
  rldf_tx_t txState;
  wire logic enterCall;

  // (R18) interval timer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tickCnt <= '0;
      callMs <= '0;
      callPend <= 1'b0;
    end else if (clkEn) begin
      tickCnt <= msTick ? 17'h00000 : tickCnt + 17'h00001;
      if (!callOn) begin
        callMs <= '0;
        callPend <= 1'b0;
      end else if (msTick) begin
        callMs <= (callMs >= callLimit - 21'h000001) ? 21'h000000 : callMs + 21'h000001;
        if (callMs >= callLimit - 21'h000001) begin
          callPend <= 1'b1;
        end else if (enterCall) begin
          callPend <= 1'b0;
        end
      end else if (enterCall) begin
        callPend <= 1'b0;
      end
    end
  end

  // Transmit buffer holds terminal data while the transmitter is not yet sending.
  logic [7:0] txMem [2**BUF_AW];
  logic txLastMem [2**BUF_AW];
  logic [BUF_AW:0] txWr, txRd;
  wire logic txEmpty = txWr == txRd;
  // (R11) buffering during delay
  assign hostInReady = (txWr - txRd) != 7'(2**BUF_AW);
  wire logic txPush = hostInValid && hostInReady && clkEn;

  logic [16:0] cyc;
  logic [15:0] msLeft;
  logic [15:0] txCrc;
  logic [3:0] txBlk;
  logic [1:0] crcLeft;
  logic txMsgDone;
  logic [4:0] callIdx;
  wire logic txAdv = !radioTxValid || radioTxReady;
  wire logic cntDone = cyc == 17'(MS_CYCLES - 1) && msLeft == 16'h0001;
  wire logic [7:0] popData = txMem[txRd[BUF_AW-1:0]];
  wire logic popLast = txLastMem[txRd[BUF_AW-1:0]];
  wire logic txPop = txState == TX_SEND && !txEmpty && txAdv && clkEn;
  wire logic [15:0] crcAfter = (effErr == ERR_CRC16F) ? crc16_next(txCrc, popData) :
    {8'h00, crc8_next(txCrc[7:0], popData)};
  wire logic partEnd = effErr == ERR_CRC8P && txBlk == 4'(PART_BLOCK - 1);
  wire rldf_tx_t startState = effDelay != 16'h0000 ? TX_DELAY : splitOn ? TX_FREQ : TX_SEND;
  wire logic [15:0] startMs = effDelay != 16'h0000 ? effDelay : FREQ_SWITCH_MS;
  assign enterCall = clkEn && txState == TX_IDLE && txEmpty && callPend && callLen != 5'h00;

  // (R12) receiver held off from delay to end of send
  assign radioRxEnable = (txState == TX_IDLE || txState == TX_WAITRX) && !radioTxValid;
  assign radioTxOn = txState == TX_SEND || txState == TX_CRC || txState == TX_CALL || radioTxValid;

  always_ff @(posedge clk_sys) begin
    if (txPush) begin
      txMem[txWr[BUF_AW-1:0]] <= hostIn.data;
      txLastMem[txWr[BUF_AW-1:0]] <= hostIn.last;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txState <= TX_IDLE;
      txWr <= '0;
      txRd <= '0;
      cyc <= '0;
      msLeft <= '0;
      txCrc <= '0;
      txBlk <= '0;
      crcLeft <= '0;
      txMsgDone <= 1'b0;
      callIdx <= '0;
      radioTx <= '0;
      radioTxValid <= 1'b0;
      radioTxMorse <= 1'b0;
    end else if (clkEn) begin
      if (txPush) begin
        txWr <= txWr + 7'h01;
      end
      if (radioTxValid && radioTxReady) begin
        radioTxValid <= 1'b0;
      end
      cyc <= (txState == TX_DELAY || txState == TX_FREQ || txState == TX_BACK) &&
        cyc != 17'(MS_CYCLES - 1) ? cyc + 17'h00001 : 17'h00000;
      if (cyc == 17'(MS_CYCLES - 1)) begin
        msLeft <= msLeft - 16'h0001;
      end
      unique case (txState)
        TX_IDLE: begin
          if (enterCall) begin
            txState <= TX_CALL;
            callIdx <= '0;
          end else if (!txEmpty) begin
            // (R23) wait for reception end
            if (rxPrio && radioRxBusy) begin
              txState <= TX_WAITRX;
            end else begin
              txState <= startState;
              msLeft <= startMs;
            end
          end
        end
        TX_WAITRX: if (!radioRxBusy) begin
          txState <= startState;
          msLeft <= startMs;
        end
        // (R10) start postponed
        TX_DELAY: if (cntDone) begin
          txState <= splitOn ? TX_FREQ : TX_SEND;
          msLeft <= FREQ_SWITCH_MS;
        end
        // (R15) frequency switch time
        TX_FREQ: if (cntDone) begin
          txState <= TX_SEND;
        end
        TX_BACK: if (cntDone) begin
          txState <= TX_IDLE;
        end
        TX_SEND: if (txPop) begin
          txRd <= txRd + 7'h01;
          radioTx <= '{data: popData, last: popLast && effErr == ERR_OFF};
          radioTxValid <= 1'b1;
          radioTxMorse <= 1'b0;
          txCrc <= crcAfter;
          txBlk <= txBlk + 4'h1;
          txMsgDone <= popLast;
          // (R1) checksum follows data
          if (effErr != ERR_OFF && (popLast || partEnd)) begin
            txState <= TX_CRC;
            crcLeft <= effErr == ERR_CRC16F ? 2'h2 : 2'h1;
          end else if (popLast) begin
            txCrc <= '0;
            txBlk <= '0;
            txState <= splitOn ? TX_BACK : TX_IDLE;
            msLeft <= FREQ_SWITCH_MS;
          end
        end
        TX_CRC: if (txAdv) begin
          radioTx <= '{data: crcLeft == 2'h2 ? txCrc[15:8] : txCrc[7:0],
            last: crcLeft == 2'h1 && txMsgDone};
          radioTxValid <= 1'b1;
          crcLeft <= crcLeft - 2'h1;
          if (crcLeft == 2'h1) begin
            txCrc <= '0;
            txBlk <= '0;
            txState <= txMsgDone ? (splitOn ? TX_BACK : TX_IDLE) : TX_SEND;
            msLeft <= FREQ_SWITCH_MS;
          end
        end
        // (R16) identifier keyed out
        TX_CALL: if (txAdv) begin
          radioTx <= '{data: callId[callIdx[3:0]], last: callIdx == callLen - 5'h01};
          radioTxValid <= 1'b1;
          radioTxMorse <= 1'b1;
          callIdx <= callIdx + 5'h01;
          if (callIdx == callLen - 5'h01) begin
            txState <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer; only bytes below the commit pointer are visible to the terminal.
  // A full-mode packet longer than the buffer cannot validate and is dropped as failed.
  logic [7:0] rxMem [2**BUF_AW];
  logic [BUF_AW-1:0] wrPtr, cmtPtr, rdPtr, msgBase, trlPtr;
  logic [BUF_AW-1:0] next_wr, next_cmt;
  logic [7:0] rxCrc8, next_crc8;
  logic [15:0] rxCrc16, next_crc16;
  logic [3:0] rxBlk, next_blk;
  logic rxDrop, next_drop, failNow;
  logic trlPend;
  logic [4:0] trlIdx;
  logic [7:0] trlLvl;
  wire logic rxTake = radioRxValid && radioRxEnable && clkEn;
  wire logic rxFull = wrPtr + 6'h01 == rdPtr;
  wire logic [7:0] c8 = crc8_next(rxCrc8, radioRx.data);
  wire logic [15:0] c16 = crc16_next(rxCrc16, radioRx.data);
  wire logic msgEnd = rxTake && radioRx.last;

  always_comb begin
    next_wr = wrPtr;
    next_cmt = cmtPtr;
    next_crc8 = rxCrc8;
    next_crc16 = rxCrc16;
    next_blk = rxBlk;
    next_drop = rxDrop;
    failNow = 1'b0;
    if (rxTake) begin
      if (rxDrop) begin
        next_drop = !radioRx.last;
      end else if (rxFull) begin
        next_wr = cmtPtr;
        failNow = effErr != ERR_OFF;
        next_drop = !radioRx.last;
      end else begin
        next_wr = wrPtr + 6'h01;
        next_crc8 = c8;
        next_crc16 = c16;
        next_blk = rxBlk + 4'h1;
        unique case (effErr)
          // (R2) immediate release, (R7) checksum bytes pass as data
          ERR_OFF: next_cmt = wrPtr + 6'h01;
          // (R3) block released once valid
          ERR_CRC8P: if (radioRx.last || rxBlk == 4'(PART_BLOCK)) begin
            next_blk = '0;
            next_crc8 = '0;
            if (c8 == 8'h00) begin
              next_wr = wrPtr;
              next_cmt = wrPtr;
            end else begin
              // (R4) failed block and rest dropped
              next_wr = cmtPtr;
              failNow = 1'b1;
              next_drop = !radioRx.last;
            end
          end
          // (R5) whole packet checked, (R6) CRC-8 stripped
          ERR_CRC8F: if (radioRx.last) begin
            next_wr = c8 == 8'h00 ? wrPtr : cmtPtr;
            next_cmt = c8 == 8'h00 ? wrPtr : cmtPtr;
            failNow = c8 != 8'h00;
          end
          ERR_CRC16F: if (radioRx.last) begin
            next_wr = c16 == 16'h0000 ? wrPtr - 6'h01 : cmtPtr;
            next_cmt = c16 == 16'h0000 ? wrPtr - 6'h01 : cmtPtr;
            failNow = c16 != 16'h0000;
          end
        endcase
      end
      if (radioRx.last) begin
        next_crc8 = '0;
        next_crc16 = '0;
        next_blk = '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rxTake && !rxDrop && !rxFull) begin
      rxMem[wrPtr] <= radioRx.data;
    end
  end

  wire logic emitTrl = trlPend && rdPtr == trlPtr;
  wire logic emitData = !emitTrl && rdPtr != cmtPtr;
  wire logic outLoad = clkEn && (!serOutValid || serOutReady) && (emitTrl || emitData);
  wire logic trlDone = outLoad && emitTrl && trlIdx == 5'(TRAILER_LEN - 1);

  // (R8) output waits on commit pointer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wrPtr <= '0;
      cmtPtr <= '0;
      rdPtr <= '0;
      msgBase <= '0;
      rxCrc8 <= '0;
      rxCrc16 <= '0;
      rxBlk <= '0;
      rxDrop <= 1'b0;
      trlPend <= 1'b0;
      trlPtr <= '0;
      trlIdx <= '0;
      trlLvl <= '0;
      serOut <= '0;
      serOutValid <= 1'b0;
      crcFail <= 1'b0;
      failCnt <= '0;
      rxOverflow <= 1'b0;
    end else if (clkEn) begin
      wrPtr <= next_wr;
      cmtPtr <= next_cmt;
      rxCrc8 <= next_crc8;
      rxCrc16 <= next_crc16;
      rxBlk <= next_blk;
      rxDrop <= next_drop;
      // (R25) failure pulse and count
      crcFail <= failNow;
      failCnt <= failNow ? (wrFail ? 16'h0001 : failCnt + 16'h0001) : (wrFail ? 16'h0000 : failCnt);
      rxOverflow <= rxOverflow || (rxTake && rxFull && !rxDrop);
      if (msgEnd) begin
        msgBase <= next_cmt;
      end
      if (serOutValid && serOutReady) begin
        serOutValid <= 1'b0;
      end
      if (outLoad) begin
        serOutValid <= 1'b1;
        serOut <= '{data: emitTrl ? trailer_byte(trlIdx, trlLvl) : rxMem[rdPtr], last: trlDone};
        if (emitTrl) begin
          trlIdx <= trlDone ? 5'h00 : trlIdx + 5'h01;
        end else begin
          rdPtr <= rdPtr + 6'h01;
        end
      end
      // (R14) trailer queued after delivered message
      if (msgEnd && rssiOn && next_cmt != msgBase) begin
        trlPend <= 1'b1;
        trlPtr <= next_cmt;
        trlLvl <= rxLevelDbm;
      end else if (trlDone) begin
        trlPend <= 1'b0;
      end
    end
  end

  logic [31:0] rdMux;
  always_comb begin
    unique case (regAddr)
      ADDR_CTRL: rdMux = 32'(ctrl);
      ADDR_TXDELAY: rdMux = 32'(txDelayMs);
      ADDR_CALLCFG: rdMux = {19'h0, callLen, 3'h0, callMin};
      ADDR_CHIDX: rdMux = 32'(chIdx);
      ADDR_CHNUM: rdMux = 32'(chMem[chIdx].num);
      ADDR_CHTXF: rdMux = chMem[chIdx].txFreq;
      ADDR_CHRXF: rdMux = chMem[chIdx].rxFreq;
      ADDR_CHCFG: rdMux = {24'h0, chMem[chIdx].power, 2'h0, chMem[chIdx].width};
      ADDR_CHCOUNT: rdMux = 32'(chCount);
      ADDR_CHDEFAULT: rdMux = 32'(chDefault);
      ADDR_CHSELECT: rdMux = 32'(activeIdx);
      ADDR_STATUS: rdMux = {24'h0, rxOverflow, rxOnly, callPend, rxDrop, 1'b0, txState};
      ADDR_FAILCNT: rdMux = 32'(failCnt);
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= 32'h0;
    end else if (clkEn) begin
      regRdData <= regRd ? rdMux : 32'h0;
    end
  end

endmodule

// ===== rtl/rldf_pkg.sv
/*
  Shared constants and types of the radio link data-feature block.
  Assumes a 100 MHz system clock and a plain register port with 8-bit addresses.
*/
package rldf_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TXDELAY = 8'h04;
  localparam logic [7:0] ADDR_CALLCFG = 8'h08;
  localparam logic [7:0] ADDR_CALLCHAR = 8'h0C;
  localparam logic [7:0] ADDR_CHIDX = 8'h10;
  localparam logic [7:0] ADDR_CHNUM = 8'h14;
  localparam logic [7:0] ADDR_CHTXF = 8'h18;
  localparam logic [7:0] ADDR_CHRXF = 8'h1C;
  localparam logic [7:0] ADDR_CHCFG = 8'h20;
  localparam logic [7:0] ADDR_CHCOUNT = 8'h24;
  localparam logic [7:0] ADDR_CHDEFAULT = 8'h28;
  localparam logic [7:0] ADDR_CHSELECT = 8'h2C;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_FAILCNT = 8'h34;
  // Control register fields.
  localparam int CTRL_ERR_LSB = 0;
  localparam int CTRL_RXPRIO = 2;
  localparam int CTRL_RECEIVED_SIGNAL_LEVEL = 3;
  localparam int CTRL_SPLIT = 4;
  localparam int CTRL_CALL = 5;
  localparam int CTRL_CHLIST = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] TXDELAY_RESET = 16'h0000;
  localparam logic [4:0] CALLMIN_RESET = 5'h0A;
  localparam int CALLCFG_LEN_LSB = 8;
  localparam int CHCFG_POWER_LSB = 4;
  // Sizes.
  localparam int PART_BLOCK = 8;
  localparam int BUF_AW = 6;
  localparam int CH_AW = 4;
  localparam int ID_LEN = 16;
  localparam int TRAILER_LEN = 17;
  // Checksum polynomials, initial value zero, sent most significant byte first.
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [15:0] FREQ_SWITCH_MS = 16'd40;
  localparam logic [20:0] MS_PER_MIN = 21'd60000;

  typedef enum logic [1:0] {
    ERR_OFF = 2'h0,
    ERR_CRC8P = 2'h1,
    ERR_CRC16F = 2'h2,
    ERR_CRC8F = 2'h3
  } rldf_err_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_WAITRX = 3'h1,
    TX_DELAY = 3'h3,
    TX_FREQ = 3'h2,
    TX_SEND = 3'h6,
    TX_CRC = 3'h7,
    TX_BACK = 3'h5,
    TX_CALL = 3'h4
  } rldf_tx_t;

  typedef enum logic [1:0] {
    WIDTH_12K5 = 2'h0,
    WIDTH_20K = 2'h1,
    WIDTH_25K = 2'h2
  } rldf_width_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rldf_byte_t;

  typedef struct packed {
    logic signed [15:0] num;
    logic [31:0] txFreq;
    logic [31:0] rxFreq;
    rldf_width_t width;
    logic [3:0] power;
  } rldf_chan_t;
endpackage
